// ===== fast_ide_port_control.v
// Local-bus IDE port control: buffer steering, shared status port, timing sets
//
// Functional notes
// - Non-data IDE ports run plain ISA cycles
// - ISA read/write strobes copied to drive strobes
// - Command reads keep both direction controls high
// - Status port read: system buffer off, IDE buffer on, mixed bits
// - Status bit 7 from floppy input
// - Status port write enables both buffers
// - Control and drive-select register field layout
// - Drive selector decodes timing A, B, ISA for drives 0-3; A or B only for drives 4-7
// - Pulse, recovery and setup field positions
// - Field values decode to clock counts
// - Write-back hint valid by first T2
// - Write-back hint high unless write-through
// - Write-protect hint follows protect decode
// - Drive from data port and head bit
// - Recovery counter gates data-port command start
// - Idle counter gates data-port command start
// - Idle address states while CPU owns bus
`timescale 1ns/10ps
`include "fast_ide_regs.vh"

module fast_ide_port_control (
  // Clock and reset
  input  wire        clock,
  input  wire        nrst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  // ISA state machine and bus ownership
  input  wire        isa_cycle_active,
  input  wire        dma_grant_n,
  input  wire        isa_ior_n,
  input  wire        isa_iow_n,
  input  wire [15:0] io_addr,
  input  wire [7:0]  io_wdata,
  input  wire        byte_high_n,
  // Local-bus data port request
  input  wire        data_req,
  input  wire        data_req_write,
  output reg         data_done,
  output reg         data_to_isa,
  // Pins from the drive and floppy side
  input  wire        floppy_bit_input,
  input  wire [7:0]  extended_bus,
  // Drive strobes, selects and buffer steering
  output reg         drive_read_strobe_n,
  output reg         drive_write_strobe_n,
  output reg         drive_select_0_n,
  output reg         drive_select_1_n,
  output reg  [2:0]  drive_addr,
  output reg         sys_dir_low,
  output reg         sys_dir_high,
  output reg         sys_buffer_enable_n,
  output reg         ide_buffer_enable_n,
  output reg  [7:0]  port_read_data,
  // Cache hints
  input  wire        prog_write_through,
  input  wire        bios_write_through,
  input  wire        mem_cycle,
  input  wire        write_protect_decode,
  output reg         writeback_hint,
  output reg         write_protect_hint_n
);

  localparam S_IDLE = 2'h0, S_WAIT = 2'h1, S_PULSE = 2'h2, S_HOLD = 2'h3;

  reg  [7:0] fast_ide_control, drive_low_timing_select, drive_high_timing_select;
  reg  [7:0] set_a_pulse_width, set_a_recovery_setup, set_b_pulse_width, set_b_recovery_setup;
  reg        floppy_s1, floppy_s2;
  reg  [7:0] xbus_s1, xbus_s2;
  reg  [1:0] state;
  reg  [4:0] cnt;
  reg        cur_write;
  reg        cur_set_b;
  reg  [2:0] idle_cnt;
  reg  [4:0] rec_cnt;
  reg  [3:0] head_bit;

  wire [3:0] pair_en = fast_ide_control[3:0];
  wire [3:0] hit_cmd, hit_ctl, hit_data, hit_head;
  wire [7:0] drv_set_b, drv_isa;
  wire [4:0] pulse_clocks, recovery_clocks;
  wire [2:0] setup_clocks;

  // Per connector address decode and head-bit snoop
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_pair
      wire [15:0] base = (p == 0) ? `PAIR0_BASE : (p == 1) ? `PAIR1_BASE :
                         (p == 2) ? `PAIR2_BASE : `PAIR3_BASE;
      wire [15:0] ctl  = base + `CTL_PORT_OFFSET;
      assign hit_data[p] = pair_en[p] && (io_addr == base);
      assign hit_cmd[p]  = pair_en[p] && (io_addr[15:3] == base[15:3]) &&
                           (io_addr[2:0] != 3'h0);
      assign hit_ctl[p]  = pair_en[p] && (io_addr[15:1] == ctl[15:1]);
      assign hit_head[p] = hit_cmd[p] && (io_addr[2:0] == `HEAD_PORT_LOW);
      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          head_bit[p] <= 1'b0;
        end else if (isa_cycle_active && !isa_iow_n && hit_head[p]) begin
          head_bit[p] <= io_wdata[4];
        end
      end
    end
  endgenerate

  // Per drive timing selection
  genvar d;
  generate
    for (d = 0; d < 8; d = d + 1) begin : g_drive
      wire [1:0] code;
      if (d < 4) begin : g_low
        assign code = drive_low_timing_select[2*d+1:2*d];
      end else begin : g_high
        assign code = {1'b0, drive_high_timing_select[2*(d-4)]};
      end
      // Reserved code falls back to timing A
      assign drv_set_b[d] = (code == `SEL_TIMING_B);
      assign drv_isa[d]   = (code == `SEL_ISA);
    end
  endgenerate

  wire [1:0] req_pair = hit_data[1] ? 2'h1 : hit_data[2] ? 2'h2 :
                        hit_data[3] ? 2'h3 : 2'h0;
  wire [2:0] req_drive = {req_pair, head_bit[req_pair]};
  wire       req_hit   = |hit_data;
  wire       req_fast  = req_hit && !drv_isa[req_drive];
  wire       fast_take = data_req && req_fast && (state == S_IDLE);
  wire ide_isa   = isa_cycle_active &&
                   (|(hit_cmd | hit_ctl) || (req_hit && drv_isa[req_drive]));
  wire is_status = (io_addr == `STATUS_PORT_0 && hit_ctl[0]) ||
                   (io_addr == `STATUS_PORT_1 && hit_ctl[1]);
  wire status_rd = ide_isa && is_status && !isa_ior_n;
  wire default_states = !isa_cycle_active &&
                        (dma_grant_n || fast_ide_control[`CTL_FORCE_IDLE]);
  wire fast_rd = (state == S_PULSE) && !cur_write;
  wire fast_wr = (state == S_PULSE) && cur_write;
  wire early_ok = cnt >= {4'h0, fast_ide_control[`CTL_EARLY_START]};
  wire [4:0] hold_clocks = fast_ide_control[`CTL_WRITE_HOLD] ? `HOLD_LONG : `HOLD_SHORT;

  ide_timing_decode u_decode (
    .pulse_field     (cur_set_b ? set_b_pulse_width : set_a_pulse_width),
    .rec_field       (cur_set_b ? set_b_recovery_setup : set_a_recovery_setup),
    .is_write        (cur_write),
    .pulse_clocks    (pulse_clocks),
    .recovery_clocks (recovery_clocks),
    .setup_clocks    (setup_clocks)
  );

  // Register file
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fast_ide_control         <= `RESET_CONTROL;
      drive_low_timing_select  <= `RESET_SEL;
      drive_high_timing_select <= `RESET_SEL;
      set_a_pulse_width        <= `RESET_TIMING;
      set_a_recovery_setup     <= `RESET_TIMING;
      set_b_pulse_width        <= `RESET_TIMING;
      set_b_recovery_setup     <= `RESET_TIMING;
    end else if (reg_write) begin
      case (reg_addr)
        `IDX_CONTROL:     fast_ide_control <= reg_wdata;
        `IDX_SEL_LOW:     drive_low_timing_select <= reg_wdata;
        `IDX_SEL_HIGH:    drive_high_timing_select <= reg_wdata & `SEL_HIGH_MASK;
        `IDX_A_PULSE:     set_a_pulse_width <= reg_wdata;
        `IDX_A_REC_SETUP: set_a_recovery_setup <= reg_wdata & `REC_SETUP_MASK;
        `IDX_B_PULSE:     set_b_pulse_width <= reg_wdata;
        `IDX_B_REC_SETUP: set_b_recovery_setup <= reg_wdata & `REC_SETUP_MASK;
        default: ;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `IDX_CONTROL:     reg_rdata <= fast_ide_control;
        `IDX_SEL_LOW:     reg_rdata <= drive_low_timing_select;
        `IDX_SEL_HIGH:    reg_rdata <= drive_high_timing_select;
        `IDX_A_PULSE:     reg_rdata <= set_a_pulse_width;
        `IDX_A_REC_SETUP: reg_rdata <= set_a_recovery_setup;
        `IDX_B_PULSE:     reg_rdata <= set_b_pulse_width;
        `IDX_B_REC_SETUP: reg_rdata <= set_b_recovery_setup;
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Pin synchronisers
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      floppy_s1 <= 1'b0;
      floppy_s2 <= 1'b0;
      xbus_s1   <= 8'h00;
      xbus_s2   <= 8'h00;
    end else begin
      floppy_s1 <= floppy_bit_input;
      floppy_s2 <= floppy_s1;
      xbus_s1   <= extended_bus;
      xbus_s2   <= xbus_s1;
    end
  end

  // Setup and recovery monitors run all the time, not only in data cycles
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idle_cnt <= 3'h0;
      rec_cnt  <= 5'h00;
    end else begin
      if (!default_states) begin
        idle_cnt <= 3'h0;
      end else if (idle_cnt < `IDLE_SAT) begin
        idle_cnt <= idle_cnt + 3'h1;
      end
      if (!drive_read_strobe_n || !drive_write_strobe_n) begin
        rec_cnt <= 5'h00;
      end else if (rec_cnt < `REC_SAT) begin
        rec_cnt <= rec_cnt + 5'h01;
      end
    end
  end

  // Fast data-port sequencer
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state       <= S_IDLE;
      cnt         <= 5'h00;
      cur_write   <= 1'b0;
      cur_set_b   <= 1'b0;
      data_done   <= 1'b0;
      data_to_isa <= 1'b0;
    end else begin
      data_done   <= 1'b0;
      data_to_isa <= data_req && !req_fast;
      case (state)
        S_IDLE: begin
          if (fast_take) begin
            state     <= S_WAIT;
            cnt       <= 5'h00;
            cur_write <= data_req_write;
            cur_set_b <= drv_set_b[req_drive];
          end
        end
        S_WAIT: begin
          if (early_ok && idle_cnt >= setup_clocks && rec_cnt >= recovery_clocks) begin
            state <= S_PULSE;
            cnt   <= 5'h01;
          end else if (cnt < 5'h1F) begin
            cnt <= cnt + 5'h01;
          end
        end
        S_PULSE: begin
          if (cnt >= pulse_clocks) begin
            cnt <= 5'h01;
            if (cur_write) begin
              state <= S_HOLD;
            end else begin
              state     <= S_IDLE;
              data_done <= 1'b1;
            end
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        S_HOLD: begin
          if (cnt >= hold_clocks) begin
            state     <= S_IDLE;
            data_done <= 1'b1;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Registered pin outputs
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      drive_read_strobe_n  <= 1'b1;
      drive_write_strobe_n <= 1'b1;
      drive_select_0_n     <= 1'b1;
      drive_select_1_n     <= 1'b1;
      drive_addr           <= 3'h0;
      sys_dir_low          <= 1'b1;
      sys_dir_high         <= 1'b1;
      sys_buffer_enable_n  <= 1'b0;
      ide_buffer_enable_n  <= 1'b1;
      port_read_data       <= 8'h00;
      writeback_hint       <= 1'b1;
      write_protect_hint_n <= 1'b1;
    end else begin
      drive_read_strobe_n  <= !fast_rd && !(ide_isa && !isa_ior_n);
      drive_write_strobe_n <= !fast_wr && !(ide_isa && !isa_iow_n);
      if (default_states) begin
        drive_addr       <= 3'h0;
        drive_select_0_n <= 1'b0;
        drive_select_1_n <= 1'b1;
      end else begin
        drive_addr[1:0]  <= io_addr[1:0];
        // Keeps the byte-high pin usable when the substitution is off
        drive_addr[2]    <= (ide_isa && fast_ide_control[`CTL_BYTE_HIGH_A2]) ?
                            io_addr[2] : byte_high_n;
        drive_select_0_n <= !(ide_isa && !(|hit_ctl));
        drive_select_1_n <= !(ide_isa && |hit_ctl);
      end
      // Reads leave direction high; writes and fast writes drive it low
      sys_dir_low  <= !(ide_isa && !isa_iow_n) && !fast_wr;
      sys_dir_high <= !(ide_isa && !isa_iow_n) && !fast_wr;
      sys_buffer_enable_n <= status_rd || (state != S_IDLE);
      ide_buffer_enable_n <= !(ide_isa || (state != S_IDLE));
      port_read_data <= {(is_status ? floppy_s2 : xbus_s2[7]), xbus_s2[6:0]};
      writeback_hint <= !(prog_write_through || bios_write_through);
      write_protect_hint_n <= !(mem_cycle && write_protect_decode);
    end
  end

endmodule

// ===== fast_ide_port_props.sv
// Property checker for the fast IDE port control block
`timescale 1ns/10ps
`include "fast_ide_regs.vh"

module fast_ide_port_props (
  // Clock and reset
  input wire        clock,
  input wire        nrst,
  // Register port
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_write,
  input wire        reg_read,
  input wire [7:0]  reg_rdata,
  // ISA side
  input wire        isa_cycle_active,
  input wire        dma_grant_n,
  input wire        isa_ior_n,
  input wire        isa_iow_n,
  input wire [15:0] io_addr,
  // Data port requests
  input wire        data_req,
  input wire        data_done,
  input wire        data_to_isa,
  // Drive side
  input wire        drive_read_strobe_n,
  input wire        drive_write_strobe_n,
  input wire        drive_select_0_n,
  input wire        drive_select_1_n,
  input wire [2:0]  drive_addr,
  input wire        sys_dir_low,
  input wire        sys_dir_high,
  input wire        sys_buffer_enable_n,
  input wire        ide_buffer_enable_n,
  // Cache hints
  input wire        prog_write_through,
  input wire        bios_write_through,
  input wire        mem_cycle,
  input wire        write_protect_decode,
  input wire        writeback_hint,
  input wire        write_protect_hint_n
);
  localparam [15:0] CMD_PORT = `PAIR0_BASE + 16'h0007;
  localparam [15:0] OFF_PORT = `PAIR2_BASE + 16'h0007;
  localparam [15:0] HEAD_PORT = `PAIR0_BASE + 16'h0006;
  logic [7:0] ctl;
  wire        isa_rd = isa_cycle_active && !isa_ior_n;
  wire        isa_wr = isa_cycle_active && !isa_iow_n;

  // Shadow of the control register, so pair enables are known here
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctl <= 8'h00;
    end else if (reg_write && reg_addr == `IDX_CONTROL) begin
      ctl <= reg_wdata;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  a_read_copy: assert property (isa_rd && io_addr == CMD_PORT && ctl[0]
    |=> !drive_read_strobe_n && !ide_buffer_enable_n) else $error("read strobe not copied");
  a_write_copy: assert property (isa_wr && io_addr == HEAD_PORT && ctl[0]
    |=> !drive_write_strobe_n && !sys_dir_low) else $error("write strobe not copied");
  a_read_dir_high: assert property (isa_rd && io_addr == CMD_PORT && ctl[0]
    |=> sys_dir_low && sys_dir_high) else $error("direction low on command read");
  a_status_read: assert property (isa_rd && io_addr == `STATUS_PORT_0 && ctl[0]
    |=> sys_buffer_enable_n && !drive_select_1_n) else $error("status read steering wrong");
  a_status_write: assert property (isa_wr && io_addr == `STATUS_PORT_0 && ctl[0]
    |=> !sys_buffer_enable_n && !ide_buffer_enable_n) else $error("status write buffers off");
  a_pair_off: assert property (isa_rd && io_addr == OFF_PORT && !ctl[2]
    |=> drive_read_strobe_n && ide_buffer_enable_n) else $error("disabled pair was driven");
  a_refuse_isa: assert property (data_req && io_addr == `PAIR2_BASE && !ctl[2]
    |=> data_to_isa) else $error("disabled pair request not handed to ISA");
  a_req_answer: assert property (data_req
    |-> ##[1:120] (data_done || data_to_isa)) else $error("data request never answered");
  a_idle_states: assert property (!isa_cycle_active && dma_grant_n
    |=> !drive_select_0_n && drive_select_1_n && drive_addr == 3'h0)
    else $error("idle address states not held");
  a_wb_hint: assert property (1'b1
    |=> writeback_hint == !$past(prog_write_through || bios_write_through))
    else $error("write-back hint wrong");
  a_wp_hint: assert property (1'b1
    |=> write_protect_hint_n == !$past(mem_cycle && write_protect_decode))
    else $error("write-protect hint wrong");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_ctl_readback: assert property (reg_read && reg_addr == `IDX_CONTROL
    |=> reg_rdata == ctl) else $error("control readback wrong");

  c_fast_done: cover property (data_done);
  c_to_isa: cover property (data_to_isa);
  c_status_rd: cover property (isa_rd && io_addr == `STATUS_PORT_0);
endmodule

bind fast_ide_port_control fast_ide_port_props fast_ide_port_props_i (
  .clock, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .isa_cycle_active, .dma_grant_n, .isa_ior_n, .isa_iow_n, .io_addr, .data_req,
  .data_done, .data_to_isa, .drive_read_strobe_n, .drive_write_strobe_n,
  .drive_select_0_n, .drive_select_1_n, .drive_addr, .sys_dir_low, .sys_dir_high,
  .sys_buffer_enable_n, .ide_buffer_enable_n, .prog_write_through, .bios_write_through,
  .mem_cycle, .write_protect_decode, .writeback_hint, .write_protect_hint_n);

// ===== fast_ide_regs.vh
// Index offsets, field positions, port addresses and timing limits of the fast IDE port
`ifndef FAST_IDE_REGS_VH
`define FAST_IDE_REGS_VH

`define IDX_CONTROL       8'h41
`define IDX_SEL_LOW       8'h42
`define IDX_SEL_HIGH      8'h43
`define IDX_A_PULSE       8'h44
`define IDX_A_REC_SETUP   8'h45
`define IDX_B_PULSE       8'h46
`define IDX_B_REC_SETUP   8'h47

`define CTL_FORCE_IDLE    7
`define CTL_BYTE_HIGH_A2  6
`define CTL_WRITE_HOLD    5
`define CTL_EARLY_START   4

`define RESET_CONTROL     8'h00
`define RESET_SEL         8'h00
`define RESET_TIMING      8'h00
`define SEL_HIGH_MASK     8'h55
`define REC_SETUP_MASK    8'h3F

`define SEL_TIMING_A      2'h0
`define SEL_TIMING_B      2'h1
`define SEL_RESERVED      2'h2
`define SEL_ISA           2'h3

`define PAIR0_BASE        16'h01F0
`define PAIR1_BASE        16'h0170
`define PAIR2_BASE        16'h05F0
`define PAIR3_BASE        16'h0570
`define CTL_PORT_OFFSET   16'h0206
`define HEAD_PORT_LOW     3'h6
`define STATUS_PORT_0     16'h03F7
`define STATUS_PORT_1     16'h0377

`define PULSE_ZERO_CLKS   5'h10
`define REC_ZERO_CLKS     5'h18
`define REC_LINEAR_MAX    4'h8
`define REC_STEP_OFFSET   5'h08
`define SETUP_ZERO_CLKS   3'h4
`define IDLE_SAT          3'h4
`define REC_SAT           5'h18
`define HOLD_SHORT        5'h01
`define HOLD_LONG         5'h02

`endif

// ===== ide_drive_model.sv
// Behavioural drive that answers reads on the extended data bus
`timescale 1ns/10ps

module ide_drive_model (
  // Clock and read strobe
  input  wire        clock,
  input  wire        read_strobe_n,
  // Byte the drive returns
  input  wire  [7:0] answer,
  // Extended data bus
  output logic [7:0] bus
);
  initial bus = 8'h00;
  // No pull-ups here, so a released bus flips every cycle
  always @(posedge clock) begin
    if (!read_strobe_n) begin
      bus <= answer;
    end else begin
      bus <= ~bus;
    end
  end
endmodule

// ===== ide_timing_decode.v
// Turns one timing set's packed fields into clock counts
`timescale 1ns/10ps
`include "fast_ide_regs.vh"

module ide_timing_decode (
  // Packed timing fields
  input  wire [7:0] pulse_field,
  input  wire [7:0] rec_field,
  input  wire       is_write,
  // Decoded counts
  output reg  [4:0] pulse_clocks,
  output reg  [4:0] recovery_clocks,
  output reg  [2:0] setup_clocks
);

  reg [3:0] pulse_code;

  always @* begin
    pulse_code = is_write ? pulse_field[7:4] : pulse_field[3:0];
    if (pulse_code == 4'h0) begin
      pulse_clocks = `PULSE_ZERO_CLKS;
    end else begin
      pulse_clocks = {1'b0, pulse_code};
    end
    // Above 8 the recovery steps by two: value 9 means 10 clocks
    if (rec_field[3:0] == 4'h0) begin
      recovery_clocks = `REC_ZERO_CLKS;
    end else if (rec_field[3:0] <= `REC_LINEAR_MAX) begin
      recovery_clocks = {1'b0, rec_field[3:0]};
    end else begin
      recovery_clocks = {rec_field[3:0], 1'b0} - `REC_STEP_OFFSET;
    end
    if (rec_field[5:4] == 2'h0) begin
      setup_clocks = `SETUP_ZERO_CLKS;
    end else begin
      setup_clocks = {1'b0, rec_field[5:4]};
    end
  end

endmodule

// ===== tb_fast_ide_port_control.sv
// Self-checking bench for the fast IDE port control block
`timescale 1ns/10ps
`include "fast_ide_regs.vh"

module tb_fast_ide_port_control;
  logic        clock = 1'b0, nrst = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic        isa_cycle_active = 1'b0, dma_grant_n = 1'b1, byte_high_n = 1'b1;
  logic        isa_ior_n = 1'b1, isa_iow_n = 1'b1, data_req = 1'b0, data_req_write = 1'b0;
  logic        floppy_bit_input = 1'b0, prog_write_through = 1'b0, bios_write_through = 1'b0;
  logic        mem_cycle = 1'b0, write_protect_decode = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, io_wdata = 8'h00, answer = 8'h00;
  logic [15:0] io_addr = 16'h0000;
  logic [31:0] rs = 32'h0001545C;
  logic [7:0]  regm [64:72];
  logic [3:0]  pv [3] = '{4'h1, 4'h0, 4'h6};
  logic [3:0]  rv [3] = '{4'h1, 4'h9, 4'h0};
  wire  [7:0]  reg_rdata, extended_bus, port_read_data;
  wire  [2:0]  drive_addr;
  wire         data_done, data_to_isa, drive_read_strobe_n, drive_write_strobe_n;
  wire         drive_select_0_n, drive_select_1_n, sys_dir_low, sys_dir_high;
  wire         sys_buffer_enable_n, ide_buffer_enable_n, writeback_hint, write_protect_hint_n;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  int          first_low, last_low, done_cyc, refused, prev_last, d0;

  fast_ide_port_control fast_ide_port_control_i (.clock, .nrst, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .isa_cycle_active, .dma_grant_n, .isa_ior_n,
    .isa_iow_n, .io_addr, .io_wdata, .byte_high_n, .data_req, .data_req_write, .data_done,
    .data_to_isa, .floppy_bit_input, .extended_bus, .drive_read_strobe_n,
    .drive_write_strobe_n, .drive_select_0_n, .drive_select_1_n, .drive_addr, .sys_dir_low,
    .sys_dir_high, .sys_buffer_enable_n, .ide_buffer_enable_n, .port_read_data,
    .prog_write_through, .bios_write_through, .mem_cycle, .write_protect_decode,
    .writeback_hint, .write_protect_hint_n);
  ide_drive_model ide_drive_model_i (.clock(clock), .read_strobe_n(drive_read_strobe_n),
    .answer(answer), .bus(extended_bus));

  always #10 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function int pulse_clks(input int v);
    return (v == 0) ? 16 : v;
  endfunction
  function int rec_clks(input int v);
    return (v == 0) ? 24 : (v <= 8) ? v : 2 * v - 8;
  endfunction
  function logic [7:0] reg_mask(input int a);
    if (a == 8'h43) return `SEL_HIGH_MASK;
    if (a == 8'h45 || a == 8'h47) return `REC_SETUP_MASK;
    return (a >= 8'h41 && a <= 8'h47) ? 8'hFF : 8'h00;
  endfunction

  task test_done();
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    if (a >= 8'h40 && a <= 8'h48) regm[a] = d & reg_mask(a);
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk("reg_rdata", regm[a], reg_rdata);
  endtask
  // Leaves the ISA cycle running so the caller can look at the outputs; first argument high reads
  task isa(input logic rd_cyc, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    isa_cycle_active <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    isa_ior_n <= !rd_cyc;
    isa_iow_n <= rd_cyc;
    repeat (7) @(posedge clock);
    #1;
  endtask
  task isa_end();
    @(posedge clock);
    isa_cycle_active <= 1'b0;
    isa_ior_n <= 1'b1;
    isa_iow_n <= 1'b1;
  endtask
  task fast(input logic w, input logic [15:0] a);
    int k;
    @(posedge clock);
    io_addr <= a;
    data_req <= 1'b1;
    data_req_write <= w;
    @(posedge clock);
    data_req <= 1'b0;
    first_low = 0;
    done_cyc = 0;
    refused = 0;
    for (k = 0; k < 150 && done_cyc == 0 && refused == 0; k++) begin
      #1;
      if ((w ? drive_write_strobe_n : drive_read_strobe_n) === 1'b0) begin
        if (first_low == 0) first_low = cyc;
        last_low = cyc;
      end
      if (data_done === 1'b1) done_cyc = cyc;
      if (data_to_isa === 1'b1) refused = 1;
      @(posedge clock);
    end
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    test_done();
  end

  initial begin
    logic [31:0] r;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    for (int a = 64; a <= 72; a++) regm[a] = 8'h00;
    for (int a = 64; a <= 72; a++) rd(a[7:0]);
    for (int a = 64; a <= 72; a++) wr(a[7:0], 8'(rnd()));
    for (int a = 64; a <= 72; a++) rd(a[7:0]);
    wr(8'h41, 8'hC3);
    wr(8'h42, 8'hF4);
    wr(8'h43, 8'h0F);
    isa(1'b1, 16'h01F7, 8'h00);
    chk("read_strobe_n", 8'h00, {7'h00, drive_read_strobe_n});
    chk("ide_buffer_enable_n", 8'h00, {7'h00, ide_buffer_enable_n});
    chk("sys_dir", 8'h03, {6'h00, sys_dir_high, sys_dir_low});
    isa_end();
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      @(posedge clock);
      answer <= r[7:0];
      floppy_bit_input <= ~r[7];
      isa(1'b1, `STATUS_PORT_0, 8'h00);
      chk("port_read_data", {~r[7], r[6:0]}, port_read_data);
      chk("sys_buffer_enable_n", 8'h01, {7'h00, sys_buffer_enable_n});
      isa_end();
    end
    isa(1'b0, `STATUS_PORT_0, 8'(rnd()));
    chk("status_write_buffers", 8'h00, {6'h00, sys_buffer_enable_n, ide_buffer_enable_n});
    isa_end();
    isa(1'b1, `PAIR2_BASE + 16'h0007, 8'h00);
    chk("off_pair_strobe", 8'h03, {6'h00, drive_read_strobe_n, ide_buffer_enable_n});
    isa_end();
    isa(1'b0, `PAIR0_BASE + 16'h0006, 8'h00);
    isa_end();
    for (int i = 0; i < 3; i++) begin
      wr(8'h44, {pv[i], pv[i]});
      wr(8'h45, {4'h1, rv[i]});
      fast(1'b0, `PAIR0_BASE);
      prev_last = last_low;
      fast(1'b0, `PAIR0_BASE);
      chk("read_pulse", 8'(pulse_clks(pv[i])), 8'(last_low - first_low + 1));
      chk("recovery_met", 8'h01, {7'h00, first_low - prev_last - 1 >= rec_clks(rv[i])});
      chk("read_done", 8'h00, 8'(done_cyc - last_low));
    end
    isa(1'b0, `PAIR0_BASE + 16'h0006, 8'h10);
    isa_end();
    for (int j = 0; j < 2; j++) begin
      wr(8'h41, 8'hC3 | 8'(j << 5));
      wr(8'h46, j ? 8'h01 : 8'h31);
      wr(8'h47, 8'h11);
      fast(1'b1, `PAIR0_BASE);
      chk("write_pulse", j ? 8'h10 : 8'h03, 8'(last_low - first_low + 1));
      chk("write_hold", 8'(j + 1), 8'(done_cyc - last_low));
      if (j == 0) d0 = done_cyc - last_low;
      else chk("write_hold_step", 8'h01, 8'(done_cyc - last_low - d0));
    end
    isa(1'b0, `PAIR1_BASE + 16'h0006, 8'h00);
    isa_end();
    fast(1'b0, `PAIR1_BASE);
    chk("isa_routed", 8'h01, 8'(refused));
    fast(1'b0, `PAIR2_BASE);
    chk("pair_disabled", 8'h01, 8'(refused));
    for (int i = 0; i < 20; i++) begin
      r = rnd();
      @(posedge clock);
      {prog_write_through, bios_write_through, mem_cycle, write_protect_decode} <= r[3:0];
      @(posedge clock);
      #1;
      chk("writeback_hint", {7'h00, !(r[3] | r[2])}, {7'h00, writeback_hint});
      chk("protect_hint_n", {7'h00, !(r[1] & r[0])}, {7'h00, write_protect_hint_n});
    end
    test_done();
  end
endmodule
